// File: logic/fndc_pkg.sv
package fndc_pkg;
  // ----------------------------------------------------------------
  // fractional accumulator
  // ----------------------------------------------------------------
  localparam int FRAC_W = 10;
  localparam logic [10:0] FRAC_MOD = 11'h3E8;
  // ----------------------------------------------------------------
  // divider chain
  // ----------------------------------------------------------------
  localparam logic [1:0] PRE_DIV_NORM = 2'h2;
  localparam logic [1:0] PRE_DIV_SWAL = 2'h3;
  localparam logic [2:0] CHIP_DIV = 3'h5;
  localparam logic [1:0] SL_DIV = 2'h3;
  localparam logic [4:0] REF_HALF = 5'h0A;
  localparam logic [8:0] SEL5_WEIGHT = 9'h032;
  localparam logic [8:0] DECADE = 9'h00A;
  localparam logic [8:0] CHAIN_RST = 9'h0C8;
  localparam int CHAIN_W = 9;
  // ----------------------------------------------------------------
  // timing, 250 MHz clock
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int INTEG_NS = 200;
  localparam int SW_NS = 40;
  localparam int API_UNIT_NS = 8;
  localparam int ADC_PERIOD_US = 200;
  localparam int INTEG_CYC = (INTEG_NS * CLK_MHZ + 999) / 1000;
  localparam int SW_CYC = (SW_NS * CLK_MHZ + 999) / 1000;
  localparam int API_UNIT_CYC = (API_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int ADC_PERIOD_CYC = ADC_PERIOD_US * CLK_MHZ;
  localparam int N_API = 3;
  localparam int N_UNLOCK = 4;
  // ----------------------------------------------------------------
  // lo command line positions
  // ----------------------------------------------------------------
  localparam int CMD_TRIG_SRC = 0;
  localparam int CMD_TRIG_ARM = 1;
  localparam int CMD_FRAC_EN = 2;
  localparam int CMD_STEP = 3;
  localparam int CMD_ADC_EN = 4;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sel5;
    logic [3:0] tens;
    logic [3:0] units;
  } fndc_ratio_t;
  typedef struct packed {
    logic [3:0] tenths;
    logic [3:0] hundredths;
    logic [3:0] thousandths;
  } fndc_api_word_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_INTEG = 2'b01,
    SEQ_SAMP1 = 2'b10,
    SEQ_SAMP2 = 2'b11
  } fndc_seq_t;
endpackage

// File: logic/fndc_phase_acc.sv
module fndc_phase_acc import fndc_pkg::*; (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // step and increment
  input wire logic step_in,
  input wire logic [FRAC_W-1:0] inc_in,
  // state
  output logic [FRAC_W-1:0] acc_out,
  output logic remove_out
);
  // ----------------------------------------------------------------
  // accumulate
  // ----------------------------------------------------------------
  logic [10:0] sum;
  assign sum = {1'b0, acc_out} + {1'b0, inc_in};

  // RQ1 add per cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      acc_out <= '0;
    end else if (step_in) begin
      // RQ2 keep remainder
      acc_out <= (sum >= FRAC_MOD) ? FRAC_W'(sum - FRAC_MOD) : FRAC_W'(sum);
    end
  end

  // RQ2 overflow removes pulse
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      remove_out <= 1'b0;
    end else if (step_in) begin
      remove_out <= (sum >= FRAC_MOD);
    end
  end
endmodule

// File: logic/fndc_prescaler.sv
module fndc_prescaler import fndc_pkg::*; (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // oscillator and program
  input wire logic osc_pulse_in,
  input wire fndc_ratio_t ratio_in,
  input wire logic swallow_in,
  // outputs
  output logic stage1_out,
  output logic cycle_start_out,
  output logic chip_clk_out
);
  logic [1:0] pre_cnt_ff;
  logic swal_ff;
  logic [CHAIN_W-1:0] chain_ff;
  logic [2:0] cc_cnt_ff;
  logic [1:0] pre_div;
  logic pre_wrap;
  logic chain_end;

  // RQ6 RQ7 stage weights
  function automatic logic [CHAIN_W-1:0] chain_load(input fndc_ratio_t r);
    chain_load = CHAIN_W'(r.sel5 * SEL5_WEIGHT + r.tens * DECADE + r.units);
  endfunction

  // ----------------------------------------------------------------
  // first stage
  // ----------------------------------------------------------------
  // RQ5 two or three
  assign pre_div = swal_ff ? PRE_DIV_SWAL : PRE_DIV_NORM;
  assign pre_wrap = osc_pulse_in && (pre_cnt_ff == pre_div - 2'h1);
  assign chain_end = pre_wrap && (chain_ff <= CHAIN_W'(1));

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pre_cnt_ff <= '0;
    end else if (pre_wrap) begin
      pre_cnt_ff <= '0;
    end else if (osc_pulse_in) begin
      pre_cnt_ff <= pre_cnt_ff + 2'h1;
    end
  end

  // RQ3 one extra input cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      swal_ff <= 1'b0;
    end else if (chain_end) begin
      swal_ff <= swallow_in;
    end else if (pre_wrap) begin
      swal_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // programmable chain
  // ----------------------------------------------------------------
  // RQ8 RQ21 reload at cycle start
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      chain_ff <= CHAIN_RST;
    end else if (chain_end) begin
      chain_ff <= chain_load(ratio_in);
    end else if (pre_wrap) begin
      chain_ff <= chain_ff - CHAIN_W'(1);
    end
  end

  // RQ9 terminal pulse
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cycle_start_out <= 1'b0;
      stage1_out <= 1'b0;
    end else begin
      cycle_start_out <= chain_end;
      stage1_out <= pre_wrap;
    end
  end

  // RQ10 chip clock divide by five
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cc_cnt_ff <= '0;
      chip_clk_out <= 1'b0;
    end else begin
      chip_clk_out <= pre_wrap && (cc_cnt_ff == CHIP_DIV - 3'h1);
      if (pre_wrap) begin
        cc_cnt_ff <= (cc_cnt_ff == CHIP_DIV - 3'h1) ? 3'h0 : cc_cnt_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] osc_gap_ff;
  always_ff @(posedge mclk_in) begin
    if (rst_in || stage1_out) begin
      osc_gap_ff <= {2'b00, osc_pulse_in};
    end else if (osc_pulse_in && osc_gap_ff != 3'h7) begin
      osc_gap_ff <= osc_gap_ff + 3'h1;
    end
  end
  stage_ratio_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ5
    stage1_out |-> (osc_gap_ff == 3'h2 || osc_gap_ff == 3'h3))
    else $error("first stage ratio not two or three");
  chip_clk_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ10
    chip_clk_out |-> stage1_out)
    else $error("chip clock off first stage edge");
endmodule

// File: logic/fndc_top.sv
// Notes on behaviour
// RQ1 - each reference cycle the increment is added to the phase accumulator
// RQ2 - accumulator overflow asks for pulse removal; only the remainder is kept
// RQ3 - a removal cycle counts one more input cycle before the output pulse
// RQ4 - average ratio equals output frequency over reference, by mixing integers
// RQ5 - first stage divides by two, or three while swallowing
// RQ6 - second stage divides by a chosen integer one to five
// RQ7 - two further stages are programmable decades
// RQ8 - the chain covers ratios 250 through 600
// RQ9 - terminal divider pulse is the cycle start
// RQ10 - chip clock is first-stage output divided by five
// RQ11 - divided pulse is retimed before the phase detector
// RQ12 - a strobe loads the interpolator duration word into its latch
// RQ13 - interpolator on-times programmed; weights fall by ten each step
// RQ14 - two sample switches close in order
// RQ15 - single loop feeds divider from oscillator over four, else loop oscillator
// RQ16 - reference oscillator divided by twenty for the sum loop
// RQ17 - five command lines steer trigger, fractional, step loop and converter
// RQ18 - trigger is external or mains line, selectable
// RQ19 - each unlock flag shown, and all ORed into one status
// RQ20 - a 200 us pacing clock starts conversions
// RQ21 - new ratio and removal take effect on the next reference cycle
module fndc_top import fndc_pkg::*; #(
  parameter int unsigned PACE_CYC = ADC_PERIOD_CYC
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // oscillator edges and single loop select
  input wire logic vto_pulse_in,
  input wire logic sl_osc_pulse_in,
  input wire logic ref_osc_pulse_in,
  input wire logic single_loop_select_in,
  // program
  input wire logic [FRAC_W-1:0] frac_inc_in,
  input wire fndc_ratio_t ratio_in,
  // lo control
  input wire logic [4:0] lo_command_lines_in,
  input wire logic lo_cmd_strobe_in,
  input wire logic ext_trig_in,
  input wire logic line_trig_in,
  input wire logic [N_UNLOCK-1:0] unlock_in,
  // divider outputs
  output logic cycle_start_out,
  output logic control_logic_clock_out,
  output logic pd_pulse_out,
  output logic sum_ref_out,
  output logic pulse_remove_out,
  // interpolator and sample hold
  output logic api_latch_out,
  output fndc_api_word_t api_word_out,
  output logic [N_API-1:0] phase_interpolator_current_out,
  output logic [1:0] sample_sw_out,
  // lo control outputs
  output logic trigger_out,
  output logic step_strobe_out,
  output logic [N_UNLOCK-1:0] unlock_led_out,
  output logic lo_unlocked_out,
  output logic adc_pace_out
);
  logic [1:0] sl_cnt_ff;
  logic sl_div_ff;
  logic osc_sel;
  logic stage1;
  logic [FRAC_W-1:0] acc;
  logic [FRAC_W-1:0] inc_eff;
  logic pd_pend_ff;
  logic [4:0] ref_cnt_ff;
  logic trig_src_ff;
  logic trig_arm_ff;
  logic frac_en_ff;
  logic adc_en_ff;
  logic [15:0] pace_cnt_ff;
  fndc_seq_t seq_ff;
  logic [7:0] seq_cnt_ff;

  // ----------------------------------------------------------------
  // divider input select
  // ----------------------------------------------------------------
  // RQ15 single loop divides by four
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sl_cnt_ff <= '0;
      sl_div_ff <= 1'b0;
    end else begin
      sl_div_ff <= sl_osc_pulse_in && (sl_cnt_ff == SL_DIV);
      if (sl_osc_pulse_in) begin
        sl_cnt_ff <= sl_cnt_ff + 2'h1;
      end
    end
  end
  // RQ15 mode select
  assign osc_sel = single_loop_select_in ? sl_div_ff : vto_pulse_in;

  // ----------------------------------------------------------------
  // fractional core
  // ----------------------------------------------------------------
  // RQ4 increment gated by command
  assign inc_eff = frac_en_ff ? frac_inc_in : '0;

  fndc_phase_acc u_acc (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .step_in(cycle_start_out),
    .inc_in(inc_eff),
    .acc_out(acc),
    .remove_out(pulse_remove_out)
  );

  fndc_prescaler u_pre (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .osc_pulse_in(osc_sel),
    .ratio_in(ratio_in),
    .swallow_in(pulse_remove_out),
    .stage1_out(stage1),
    .cycle_start_out(cycle_start_out),
    .chip_clk_out(control_logic_clock_out)
  );

  // ----------------------------------------------------------------
  // phase detector retiming
  // ----------------------------------------------------------------
  // RQ11 release on next oscillator edge
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pd_pend_ff <= 1'b0;
      pd_pulse_out <= 1'b0;
    end else begin
      pd_pulse_out <= pd_pend_ff && osc_sel;
      if (cycle_start_out) begin
        pd_pend_ff <= 1'b1;
      end else if (osc_sel) begin
        pd_pend_ff <= 1'b0;
      end
    end
  end

  // RQ16 reference divide by twenty
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ref_cnt_ff <= '0;
      sum_ref_out <= 1'b0;
    end else if (ref_osc_pulse_in) begin
      if (ref_cnt_ff == REF_HALF - 5'h01) begin
        ref_cnt_ff <= '0;
        sum_ref_out <= !sum_ref_out;
      end else begin
        ref_cnt_ff <= ref_cnt_ff + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // interpolator
  // ----------------------------------------------------------------
  // RQ12 latch strobe and word
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      api_latch_out <= 1'b0;
      api_word_out <= '0;
    end else begin
      api_latch_out <= cycle_start_out;
      if (cycle_start_out) begin
        api_word_out.tenths <= 4'(acc / 10'h064);
        api_word_out.hundredths <= 4'((acc / 10'h00A) % 10'h00A);
        api_word_out.thousandths <= 4'(acc % 10'h00A);
      end
    end
  end

  logic [3:0] api_digit [N_API];
  assign api_digit[0] = api_word_out.tenths;
  assign api_digit[1] = api_word_out.hundredths;
  assign api_digit[2] = api_word_out.thousandths;

  // RQ13 on-time per current
  for (genvar i = 0; i < N_API; i++) begin : g_api
    logic [7:0] on_cnt_ff;
    always_ff @(posedge mclk_in) begin
      if (rst_in) begin
        on_cnt_ff <= '0;
      end else if (api_latch_out) begin
        on_cnt_ff <= 8'(api_digit[i] * API_UNIT_CYC);
      end else if (on_cnt_ff != 8'h00) begin
        on_cnt_ff <= on_cnt_ff - 8'h01;
      end
    end
    assign phase_interpolator_current_out[i] = (on_cnt_ff != 8'h00);
  end

  // ----------------------------------------------------------------
  // sample hold sequence
  // ----------------------------------------------------------------
  // RQ14 integrate then two samples
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      seq_ff <= SEQ_IDLE;
      seq_cnt_ff <= '0;
    end else begin
      case (seq_ff)
        SEQ_IDLE: begin
          if (pd_pulse_out) begin
            seq_ff <= SEQ_INTEG;
            seq_cnt_ff <= 8'(INTEG_CYC - 1);
          end
        end
        SEQ_INTEG: begin
          if (seq_cnt_ff == 8'h00) begin
            seq_ff <= SEQ_SAMP1;
            seq_cnt_ff <= 8'(SW_CYC - 1);
          end else begin
            seq_cnt_ff <= seq_cnt_ff - 8'h01;
          end
        end
        SEQ_SAMP1: begin
          if (seq_cnt_ff == 8'h00) begin
            seq_ff <= SEQ_SAMP2;
            seq_cnt_ff <= 8'(SW_CYC - 1);
          end else begin
            seq_cnt_ff <= seq_cnt_ff - 8'h01;
          end
        end
        SEQ_SAMP2: begin
          if (seq_cnt_ff == 8'h00) begin
            seq_ff <= SEQ_IDLE;
          end else begin
            seq_cnt_ff <= seq_cnt_ff - 8'h01;
          end
        end
        default: seq_ff <= SEQ_IDLE;
      endcase
    end
  end
  assign sample_sw_out = {seq_ff == SEQ_SAMP2, seq_ff == SEQ_SAMP1};

  // ----------------------------------------------------------------
  // lo control
  // ----------------------------------------------------------------
  // RQ17 steer command lines
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      trig_src_ff <= 1'b0;
      trig_arm_ff <= 1'b0;
      frac_en_ff <= 1'b1;
      adc_en_ff <= 1'b0;
      step_strobe_out <= 1'b0;
    end else begin
      step_strobe_out <= lo_cmd_strobe_in && lo_command_lines_in[CMD_STEP];
      if (lo_cmd_strobe_in) begin
        trig_src_ff <= lo_command_lines_in[CMD_TRIG_SRC];
        trig_arm_ff <= lo_command_lines_in[CMD_TRIG_ARM];
        frac_en_ff <= lo_command_lines_in[CMD_FRAC_EN];
        adc_en_ff <= lo_command_lines_in[CMD_ADC_EN];
      end
    end
  end

  // RQ18 trigger source select, RQ19 unlock flags
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      trigger_out <= 1'b0;
      unlock_led_out <= '0;
      lo_unlocked_out <= 1'b0;
    end else begin
      trigger_out <= trig_arm_ff && (trig_src_ff ? line_trig_in : ext_trig_in);
      unlock_led_out <= unlock_in;
      lo_unlocked_out <= |unlock_in;
    end
  end

  // RQ20 pacing clock
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pace_cnt_ff <= '0;
      adc_pace_out <= 1'b0;
    end else begin
      adc_pace_out <= adc_en_ff && (pace_cnt_ff == 16'(PACE_CYC - 1));
      pace_cnt_ff <= (pace_cnt_ff == 16'(PACE_CYC - 1)) ? 16'h0000 : pace_cnt_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [10:0] chk_sum;
  assign chk_sum = {1'b0, acc} + {1'b0, inc_eff};
  acc_overflow_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ2
    cycle_start_out |=> pulse_remove_out == ($past(chk_sum) >= FRAC_MOD))
    else $error("removal does not match overflow");
  acc_remainder_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ1
    cycle_start_out |=> 11'(acc) == ($past(chk_sum) % FRAC_MOD))
    else $error("accumulator lost increment");
  pd_retime_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ11
    pd_pulse_out |-> $past(osc_sel) && $past(pd_pend_ff) && !$past(cycle_start_out))
    else $error("phase detector pulse not retimed");
  latch_strobe_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ12
    cycle_start_out |=> api_latch_out ##1 !api_latch_out)
    else $error("latch strobe missing");
  api_ontime_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ13
    api_latch_out |=> phase_interpolator_current_out[0] == (api_word_out.tenths != 4'h0))
    else $error("interpolator on-time wrong");
  sample_order_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ14
    $fell(sample_sw_out[0]) |-> sample_sw_out[1] && !sample_sw_out[0])
    else $error("sample switches out of order");
  unlock_or_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ19
    ##1 lo_unlocked_out == |$past(unlock_in))
    else $error("unlock status not ORed");
  trig_select_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ18
    trig_arm_ff && !trig_src_ff && ext_trig_in |=> trigger_out)
    else $error("external trigger not passed");
  pace_gap_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ20
    adc_pace_out |-> pace_cnt_ff == 16'h0000)
    else $error("pacing clock off period");
  removal_cycle_c: cover property (@(posedge mclk_in) disable iff (rst_in)
    cycle_start_out ##1 pulse_remove_out);
  second_sample_c: cover property (@(posedge mclk_in) disable iff (rst_in)
    $rose(sample_sw_out[1]));
  pace_fire_c: cover property (@(posedge mclk_in) disable iff (rst_in) adc_pace_out);
  unlocked_c: cover property (@(posedge mclk_in) disable iff (rst_in) lo_unlocked_out);
endmodule

// File: dv/fndc_osc_model.sv
module fndc_osc_model (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // pace
  input wire logic slow_in,
  // oscillator edges
  output logic vto_pulse_out,
  output logic sl_pulse_out,
  output logic ref_pulse_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt_ff;
  logic ph_ff;
  logic rst_ff;
  logic slow_ff;
  initial begin
    vto_pulse_out = 1'b0;
    sl_pulse_out = 1'b0;
    ref_pulse_out = 1'b0;
    cnt_ff = 2'h0;
    ph_ff = 1'b0;
  end
  // edges every two or three clocks
  // controls taken at the edge, before the bench moves them
  always @(posedge mclk_in) begin
    rst_ff = rst_in;
    slow_ff = slow_in;
    #1;
    cnt_ff = (rst_ff || cnt_ff >= (slow_ff ? 2'h2 : 2'h1)) ? 2'h0 : cnt_ff + 2'h1;
    ph_ff = rst_ff ? 1'b0 : ~ph_ff;
    vto_pulse_out = !rst_ff && cnt_ff == 2'h0;
    sl_pulse_out = ph_ff;
    ref_pulse_out = ph_ff;
  end
endmodule

// File: dv/tb_top.sv
module tb_top import fndc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int n; int total;} fndc_exp_t;
  logic mclk_in, rst_in, vto, slp, refp, sel, slow, strobe, ext_t, line_t;
  logic cs, cc, pd, sref, prm, lat, trig, step, unl, pace, sr_q, lat_q, act;
  logic [FRAC_W-1:0] finc;
  logic [4:0] lines;
  logic [3:0] unlk, led;
  logic [2:0] phase_interpolator_current;
  logic [1:0] sw;
  fndc_ratio_t ratio;
  fndc_api_word_t word;
  int checks, fail_count, seed, cs_n, osc, acc, left, p;
  int cc_n, pd_n, lat_n, sw0_n, sw1_n, both_n, st_n, pace_n, rm_n;
  int rgap, rgap_l, pgap, pgap_l;
  int ln[3], dg[3];
  int mv[3] = '{125, 300, 250};
  fndc_ratio_t rt[3] = '{'{3'h1, 4'h7, 4'h5}, '{3'h5, 4'h5, 4'h0}, '{3'h5, 4'h0, 4'h0}};
  fndc_exp_t q[$], cur;

  always #2 mclk_in = ~mclk_in;

  fndc_osc_model fndc_osc_model_i (.mclk_in(mclk_in), .rst_in(rst_in), .slow_in(slow),
    .vto_pulse_out(vto), .sl_pulse_out(slp), .ref_pulse_out(refp));

  fndc_top #(.PACE_CYC(20)) fndc_top_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .vto_pulse_in(vto), .sl_osc_pulse_in(slp), .ref_osc_pulse_in(refp),
    .single_loop_select_in(sel), .frac_inc_in(finc), .ratio_in(ratio),
    .lo_command_lines_in(lines), .lo_cmd_strobe_in(strobe), .ext_trig_in(ext_t),
    .line_trig_in(line_t), .unlock_in(unlk), .cycle_start_out(cs),
    .control_logic_clock_out(cc), .pd_pulse_out(pd), .sum_ref_out(sref),
    .pulse_remove_out(prm), .api_latch_out(lat), .api_word_out(word),
    .phase_interpolator_current_out(phase_interpolator_current), .sample_sw_out(sw), .trigger_out(trig),
    .step_strobe_out(step), .unlock_led_out(led), .lo_unlocked_out(unl),
    .adc_pace_out(pace));

  // ----
  // checking
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic wait_cs(input int n);
    int t0;
    int k;
    t0 = cs_n;
    k = 0;
    while (cs_n < t0 + n) begin
      tick(1);
      k++;
      if (k > n * 5000) begin
        fail_count++;
        $display("wrong value cycle start expected %0d seen %0d", n, cs_n - t0);
        print_verdict();
      end
    end
  endtask

  task automatic clr();
    {cc_n, pd_n, lat_n, sw0_n, sw1_n, both_n, st_n, pace_n, rm_n} = '0;
    ln = '{0, 0, 0};
    dg = '{0, 0, 0};
  endtask

  task automatic send(input logic [4:0] l);
    lines = l;
    strobe = 1'b1;
    tick(1);
    strobe = 1'b0;
    tick(3);
  endtask

  // monitor, oldest expectation taken at a cycle start once no expectation is active
  always @(negedge mclk_in) begin
    p = int'(sel ? slp : vto);
    cc_n += int'(cc === 1'b1);
    pd_n += int'(pd === 1'b1);
    lat_n += int'(lat === 1'b1);
    rm_n += int'(lat === 1'b1 && prm === 1'b1);
    st_n += int'(step === 1'b1);
    pace_n += int'(pace === 1'b1);
    sw0_n += int'(sw === 2'h1);
    sw1_n += int'(sw === 2'h2);
    both_n += int'(sw === 2'h3);
    for (int i = 0; i < 3; i++) ln[i] += int'(phase_interpolator_current[i] === 1'b1);
    if (lat_q) begin
      dg[0] += int'(word.tenths);
      dg[1] += int'(word.hundredths);
      dg[2] += int'(word.thousandths);
    end
    lat_q = (lat === 1'b1);
    if (sref !== sr_q) begin
      rgap_l = rgap;
      rgap = 0;
    end
    rgap += int'(refp);
    sr_q = sref;
    pgap++;
    if (pace === 1'b1) begin
      pgap_l = pgap;
      pgap = 0;
    end
    if (cs === 1'b1) begin
      cs_n++;
      if (act) begin
        acc += osc;
        left--;
        if (left == 0) begin
          check("divider count", acc, cur.total);
          act = 1'b0;
        end
      end
      if (!act && q.size() > 0) begin
        cur = q.pop_front();
        act = 1'b1;
        acc = 0;
        left = cur.n;
      end
      osc = p;
    end else begin
      osc += p;
    end
  end

  // ----
  // sequence
  // ----
  initial begin
    {mclk_in, sel, slow, strobe, ext_t, line_t, act, lat_q, sr_q} = '0;
    {checks, fail_count, cs_n, osc, acc, left, rgap, rgap_l, pgap, pgap_l} = '0;
    seed = 39738;
    finc = '0;
    lines = 5'h00;
    unlk = 4'h0;
    ratio = rt[0];
    clr();
    rst_in = 1'b1;
    tick(12);
    rst_in = 1'b0;
    for (int i = 0; i < 3; i++) begin
      ratio = rt[i];
      slow = i[0];
      wait_cs(2);
      q.push_back('{2, 4 * mv[i]});
      wait_cs(3);
    end
    $display("test ratio done");
    finc = 10'h190;
    wait_cs(3);
    q.push_back('{10, 5004});
    wait_cs(1);
    clr();
    wait_cs(10);
    check("chip clock", cc_n, 500);
    check("pd pulse", pd_n, 10);
    check("latch", lat_n, 10);
    check("switch one", sw0_n, 10 * SW_CYC);
    check("switch two", sw1_n, 10 * SW_CYC);
    check("switch both", both_n, 0);
    check("tenths sum", dg[0], 40);
    check("low digits", dg[1] + dg[2], 0);
    check("removals", rm_n, 4);
    for (int i = 0; i < 3; i++) check("on time", ln[i], (i == 0) ? 40 * API_UNIT_CYC : 0);
    check("sum ref", rgap_l, 10);
    $display("test fractional done");
    send(5'h00);
    wait_cs(3);
    q.push_back('{4, 2000});
    wait_cs(6);
    $display("test frac enable done");
    clr();
    for (int i = 0; i < 4; i++) begin
      ext_t = 1'($random(seed));
      line_t = !ext_t;
      send({3'h3, i[1:0]});
      check("trigger", trig, i[1] & (i[0] ? line_t : ext_t));
    end
    check("step strobe", st_n, 4);
    for (int i = 0; i < 8; i++) begin
      unlk = (i == 0) ? 4'h0 : 4'($random(seed));
      tick(2);
      check("unlock led", led, unlk);
      check("lo unlocked", unl, |unlk);
    end
    send(5'h14);
    tick(60);
    check("pace period", pgap_l, 20);
    send(5'h04);
    clr();
    tick(60);
    check("pace off", pace_n, 0);
    $display("test lo control done");
    sel = 1'b1;
    finc = '0;
    wait_cs(3);
    q.push_back('{2, 4000});
    wait_cs(4);
    $display("test single loop done");
    check("queue left", q.size() + int'(act), 0);
    print_verdict();
  end
endmodule
